// ==== core/cpu_idle_timer.sv ====
// Purpose: counts pci clocks of cpu inactivity
// Assumes: strobes synchronous to clk
// Notes: inactive flag is decoded from the count and run flag, not registered
`timescale 1ns/1ps
module cpu_idle_timer
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cpuBurstReady,
    input wire logic cpuAddrStrobe,
    input wire logic [2:0] idleSel,
    output logic cpuIdle
);
    import pci_policy_pkg::*;

    logic [3:0] count_q;
    logic running_q;
    wire logic [3:0] limit = {1'b0, idleSel} + 4'h1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= 4'h0;
            running_q <= 1'b0;
        end
        else if (cpuAddrStrobe)
        begin
            count_q <= 4'h0;
            running_q <= 1'b0;
        end
        else if (cpuBurstReady)
        begin
            count_q <= 4'h0;
            running_q <= 1'b1;
        end
        else if (running_q && count_q < IDLE_MAX)
        begin
            count_q <= count_q + 4'h1;
        end
    end

    assign cpuIdle = running_q && (count_q >= limit);
endmodule

// ==== core/pci_concurrency_arbitration_control.sv ====
// Purpose: pci arbitration and concurrency policy of the host bridge
// Assumes: register port reads answer one cycle after the strobe
// Notes:
// Notes on behaviour
// - inactivity timer counts pci clocks
// - idle window: burst-ready to next strobe
// - timeout is field value plus one
// - active cpu is default bus owner
// - idle cpu yields to hold and masters
// - no peer overlap: back off cpu
// - peer overlap lets cpu reach memory
// - burst disable stops cpu pci bursts except qword writes
// - burst disable leaves posting, dram bursts
// - stream disable snoops start address only
// - stream disable disconnects at line end
// - overlap disable: drain, then grant
// - overlap disable forbids cpu concurrency
`timescale 1ns/1ps
module pci_concurrency_arbitration_control
(
    input wire logic clk,
    input wire logic rst_n,
    input wire pci_policy_pkg::reg_req_t regReq,
    output logic [7:0] regRdata,
    input wire logic cpuBurstReady_n,
    input wire logic cpuAddressStrobe_n,
    input wire pci_policy_pkg::pci_req_t pciReq,
    input wire logic peerTraffic,
    input wire logic peerLocked,
    input wire logic cpuMemCycle,
    input wire logic cpuPciWrite,
    input wire logic cpuQwordWrite,
    input wire logic cpuPciBufEmpty,
    input wire logic dramBufEmpty,
    input wire logic hostBusAck,
    input wire logic pciDramXfer,
    input wire logic pciDramStart,
    input wire logic [1:0] pciDwordIndex,
    input wire logic pciBusIdle,
    output pci_policy_pkg::pci_req_t pciGrant,
    output logic cpuOwnsPci,
    output logic cpuBackoff,
    output logic hostBusRequest,
    output logic cpuPciBurstEn,
    output logic cpuPciPostEn,
    output logic snoopStrobe,
    output logic pciDisconnect,
    output logic cpuIdleFlag
);
    import pci_policy_pkg::*;

    // ************************************************************
    // register port
    // ************************************************************
    logic [7:0] policy_q;
    logic [7:0] rdata_q;

    wire logic hitPolicy = (regReq.addr == POLICY_OFFSET);
    wire logic [2:0] idleSel = policy_q[IDLE_SEL_HI:IDLE_SEL_LO];
    wire logic peerOverlap = policy_q[PEER_OVERLAP_BIT];
    wire logic burstDis = policy_q[BURST_DIS_BIT];
    wire logic streamDis = policy_q[STREAM_DIS_BIT];
    wire logic overlapDis = policy_q[OVERLAP_DIS_BIT];
    wire logic [7:0] rdNext = hitPolicy ? policy_q : 8'h00;

    // policy write, reserved bit 4 kept zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            policy_q <= POLICY_RESET;
        else if (regReq.wr && hitPolicy)
            policy_q <= regReq.wdata & POLICY_WMASK;
    end

    // read data in the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else
            rdata_q <= regReq.rd ? rdNext : 8'h00;
    end
    assign regRdata = rdata_q;

    // ************************************************************
    // cpu inactivity
    // ************************************************************
    logic cpuIdle;
    logic idle_q;

    cpu_idle_timer idleTimer
    (
        .clk(clk),
        .rst_n(rst_n),
        .cpuBurstReady(!cpuBurstReady_n),
        .cpuAddrStrobe(!cpuAddressStrobe_n),
        .idleSel(idleSel),
        .cpuIdle(cpuIdle)
    );

    // ************************************************************
    // arbitration
    // ************************************************************
    own_t own_q;
    own_t own_d;
    pci_req_t grant_q;
    pci_req_t grant_d;
    logic [1:0] rr_q;

    wire logic anyReq = pciReq.bridgeHold || (|pciReq.masters);
    wire logic buffersEmpty = cpuPciBufEmpty && dramBufEmpty;
    // overlap disable makes every request act as hold type
    wire logic needDrain = overlapDis || pciReq.bridgeHold;

    function automatic pci_req_t pick(input pci_req_t r, input logic [1:0] rr);
        pci_req_t g;
        g = '0;
        if (r.bridgeHold)
            g.bridgeHold = 1'b1;
        else if (r.masters[rr] && rr != 2'h3)
            g.masters[rr] = 1'b1;
        else if (r.masters[0])
            g.masters[0] = 1'b1;
        else if (r.masters[1])
            g.masters[1] = 1'b1;
        else if (r.masters[2])
            g.masters[2] = 1'b1;
        return g;
    endfunction

    // owner state machine
    always_comb
    begin
        own_d = own_q;
        grant_d = grant_q;
        case (own_q)
            OWN_CPU:
            begin
                if (cpuIdle && anyReq)
                begin
                    if (needDrain)
                        own_d = OWN_DRAIN;
                    else
                    begin
                        own_d = OWN_PCI;
                        grant_d = pick(pciReq, rr_q);
                    end
                end
            end
            OWN_DRAIN:
            begin
                // host bus held, buffers drained first
                if (!anyReq)
                    own_d = OWN_CPU;
                else if (hostBusAck && buffersEmpty)
                begin
                    own_d = OWN_PCI;
                    grant_d = pick(pciReq, rr_q);
                end
            end
            OWN_PCI:
            begin
                if (pciBusIdle && ((grant_q & pciReq) == '0))
                begin
                    own_d = OWN_CPU;
                    grant_d = '0;
                end
            end
            default:
            begin
                own_d = OWN_CPU;
                grant_d = '0;
            end
        endcase
    end

    // a grant starts when the owner moves to pci
    wire logic startGrant = (own_q != OWN_PCI) && (own_d == OWN_PCI);
    wire logic [1:0] rrNext = (rr_q == 2'h2) ? 2'h0 : rr_q + 2'h1;

    // owner and grant registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            own_q <= OWN_CPU;
            grant_q <= '0;
        end
        else
        begin
            own_q <= own_d;
            grant_q <= grant_d;
        end
    end

    // master rotation steps on each new grant
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rr_q <= 2'h0;
        else if (startGrant)
            rr_q <= rrNext;
    end

    // idle flag one clock behind the timer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            idle_q <= 1'b0;
        else
            idle_q <= cpuIdle;
    end

    // ************************************************************
    // concurrency and transfer policy
    // ************************************************************
    logic backoff_q;
    logic hostReq_q;
    logic burstEn_q;
    logic postEn_q;
    logic snoop_q;
    logic disc_q;
    logic owns_q;

    // cpu memory cycles beside unlocked peers
    wire logic peerOk = peerOverlap && !overlapDis && cpuMemCycle && !peerLocked && !grant_q.bridgeHold;
    // no concurrency with peers, nor off cpu ownership under overlap disable
    wire logic backoffNext = (peerTraffic && !peerOk) || (overlapDis && own_q != OWN_CPU);
    wire logic burstNext = !burstDis || (cpuPciWrite && cpuQwordWrite);
    // snoop start only, else snoop ahead
    wire logic snoopNext = pciDramXfer && (pciDramStart || !streamDis);
    // disconnect at last dword of line
    wire logic discNext = streamDis && pciDramXfer && pciDwordIndex == DWORD_LAST;

    // host bus held through drain and hold-type grants
    wire logic hostReqNext = (own_d == OWN_DRAIN) || (own_d == OWN_PCI && needDrain);
    wire logic ownsNext = (own_d == OWN_CPU);

    // cpu backoff level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            backoff_q <= 1'b0;
        else
            backoff_q <= backoffNext;
    end

    // host bus request level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hostReq_q <= 1'b0;
        else
            hostReq_q <= hostReqNext;
    end

    // cpu to pci burst enable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            burstEn_q <= 1'b1;
        else
            burstEn_q <= burstNext;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            postEn_q <= 1'b1;
        else
            postEn_q <= 1'b1;
    end

    // snoop strobe level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            snoop_q <= 1'b0;
        else
            snoop_q <= snoopNext;
    end

    // disconnect level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            disc_q <= 1'b0;
        else
            disc_q <= discNext;
    end

    // cpu ownership level, set from reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            owns_q <= 1'b1;
        else
            owns_q <= ownsNext;
    end

    // outputs straight from their flops
    assign pciGrant = grant_q;
    assign cpuOwnsPci = owns_q;
    assign cpuBackoff = backoff_q;
    assign hostBusRequest = hostReq_q;
    assign cpuPciBurstEn = burstEn_q;
    assign cpuPciPostEn = postEn_q;
    assign snoopStrobe = snoop_q;
    assign pciDisconnect = disc_q;
    assign cpuIdleFlag = idle_q;
endmodule

// ==== core/pci_policy_pkg.sv ====
// Purpose: shared constants and types for the PCI arbitration policy block
// Assumes: 8-bit policy register at offset 0x50, 40 MHz clock
// Notes: field positions and reset value of the policy register
package pci_policy_pkg;
    localparam logic [7:0] POLICY_OFFSET = 8'h50;
    localparam logic [7:0] POLICY_RESET = 8'h40;
    localparam int IDLE_SEL_HI = 7;
    localparam int IDLE_SEL_LO = 5;
    localparam int PEER_OVERLAP_BIT = 3;
    localparam int BURST_DIS_BIT = 2;
    localparam int STREAM_DIS_BIT = 1;
    localparam int OVERLAP_DIS_BIT = 0;
    localparam logic [7:0] POLICY_WMASK = 8'hEF;
    localparam logic [1:0] DWORD_LAST = 2'h3;
    localparam logic [3:0] IDLE_MAX = 4'h8;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // pci side requests; grants are a one-hot set of the same form
    typedef struct packed {
        logic bridgeHold;
        logic [2:0] masters;
    } pci_req_t;

    typedef enum logic [1:0] {OWN_CPU, OWN_DRAIN, OWN_PCI} own_t;
endpackage

// ==== dv/host_side_model.sv ====
// Purpose: host bus and write buffer side seen by the policy block
// Assumes: buffers hold data until the host bus is requested
// Notes: ack first, then the two buffers drain one after the other
`timescale 1ns/1ps
module host_side_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hostBusRequest,
    output logic hostBusAck,
    output logic cpuPciBufEmpty,
    output logic dramBufEmpty
);
    logic [2:0] wait_q;

    // step through ack and drain while the request stands
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wait_q <= 3'h0;
        else if (!hostBusRequest)
            wait_q <= 3'h0;
        else if (wait_q != 3'h5)
            wait_q <= wait_q + 3'h1;
    end

    // slow answer: ack, then cpu buffer, then dram buffer
    assign hostBusAck = wait_q > 3'h2;
    assign cpuPciBufEmpty = wait_q > 3'h3;
    assign dramBufEmpty = wait_q == 3'h5;
endmodule

// ==== dv/pci_concurrency_arbitration_control_assertions.sv ====
// Purpose: port checks of the pci policy block
// Assumes: policy shadow follows register port writes
// Notes: outputs lag their cause by one clock, the idle flag by two clocks after an address strobe
`timescale 1ns/1ps
module pci_policy_checker
(
    input wire logic clk,
    input wire logic rst_n,
    input wire pci_policy_pkg::reg_req_t regReq,
    input wire logic [7:0] regRdata,
    input wire logic cpuBurstReady_n,
    input wire logic cpuAddressStrobe_n,
    input wire logic peerTraffic,
    input wire logic peerLocked,
    input wire logic cpuMemCycle,
    input wire logic cpuPciWrite,
    input wire logic cpuQwordWrite,
    input wire logic cpuPciBufEmpty,
    input wire logic dramBufEmpty,
    input wire logic hostBusAck,
    input wire logic pciDramXfer,
    input wire logic pciDramStart,
    input wire logic [1:0] pciDwordIndex,
    input wire pci_policy_pkg::pci_req_t pciGrant,
    input wire logic cpuOwnsPci,
    input wire logic cpuBackoff,
    input wire logic hostBusRequest,
    input wire logic cpuPciBurstEn,
    input wire logic cpuPciPostEn,
    input wire logic snoopStrobe,
    input wire logic pciDisconnect,
    input wire logic cpuIdleFlag
);
    import pci_policy_pkg::*;
    logic [7:0] pol_q;
    logic [7:0] rd_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // shadow of the policy register and expected read data
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pol_q <= POLICY_RESET;
            rd_q <= 8'h00;
        end
        else
        begin
            if (regReq.wr && regReq.addr == POLICY_OFFSET)
                pol_q <= regReq.wdata & POLICY_WMASK;
            rd_q <= (regReq.rd && regReq.addr == POLICY_OFFSET) ? pol_q : 8'h00;
        end
    end

    sequence idleWindow;
        !cpuBurstReady_n ##1 (cpuBurstReady_n && cpuAddressStrobe_n)[*8];
    endsequence

    AST_RDATA: assert property (regRdata == rd_q)
        else $error("read data differs from policy shadow");
    AST_IDLE: assert property (idleWindow |-> ##[0:2] cpuIdleFlag)
        else $error("cpu not flagged idle after longest timeout");
    AST_STROBE: assert property (!cpuAddressStrobe_n |-> ##2 !cpuIdleFlag)
        else $error("idle flag kept after address strobe");
    AST_OWNER: assert property (cpuOwnsPci |-> pciGrant == '0)
        else $error("pci granted while cpu owns bus");
    AST_DRAIN: assert property ($rose(|pciGrant) && $past(pol_q[0])
        |-> $past(hostBusRequest && hostBusAck && cpuPciBufEmpty && dramBufEmpty))
        else $error("grant before host bus drained");
    AST_BACKOFF: assert property (peerTraffic && !pol_q[3] |=> cpuBackoff)
        else $error("no backoff during peer traffic");
    AST_PEER: assert property (peerTraffic && pol_q[3] && !pol_q[0] && cpuMemCycle
        && !peerLocked && cpuOwnsPci |=> !cpuBackoff)
        else $error("backoff despite peer overlap");
    AST_NOCONC: assert property (peerTraffic && pol_q[0] |=> cpuBackoff)
        else $error("cpu concurrent with peer traffic");
    AST_BURST: assert property (cpuPciBurstEn == $past(!pol_q[2] || (cpuPciWrite && cpuQwordWrite)))
        else $error("burst enable wrong");
    AST_POST: assert property (cpuPciPostEn)
        else $error("posting disabled");
    AST_SNOOP: assert property (snoopStrobe == $past(pciDramXfer && (pciDramStart || !pol_q[1])))
        else $error("snoop strobe wrong");
    AST_DISC: assert property (pciDisconnect == $past(pol_q[1] && pciDramXfer
        && pciDwordIndex == DWORD_LAST))
        else $error("disconnect wrong");
endmodule

bind pci_concurrency_arbitration_control pci_policy_checker u_chk (.clk, .rst_n, .regReq, .regRdata,
    .cpuBurstReady_n, .cpuAddressStrobe_n, .peerTraffic, .peerLocked, .cpuMemCycle, .cpuPciWrite,
    .cpuQwordWrite, .cpuPciBufEmpty, .dramBufEmpty, .hostBusAck, .pciDramXfer, .pciDramStart,
    .pciDwordIndex, .pciGrant, .cpuOwnsPci, .cpuBackoff, .hostBusRequest, .cpuPciBurstEn,
    .cpuPciPostEn, .snoopStrobe, .pciDisconnect, .cpuIdleFlag);

// ==== dv/pci_concurrency_arbitration_control_bench.sv ====
// Purpose: self-checking bench of the pci policy block
// Assumes: 40 MHz clock, host side from host_side_model
// Notes: cpu kept busy by a held address strobe
`timescale 1ns/1ps
module pci_concurrency_arbitration_control_bench;
    import pci_policy_pkg::*;
    logic clk, rst_n, cpuBurstReady_n, cpuAddressStrobe_n, hostBusRequest, hostBusAck, cpuPciBufEmpty;
    logic dramBufEmpty, cpuOwnsPci, cpuBackoff, cpuPciBurstEn, cpuPciPostEn, snoopStrobe, pciDisconnect;
    logic cpuIdleFlag;
    logic [7:0] regRdata, st;
    logic [1:0] idx;
    reg_req_t regReq;
    pci_req_t pciReq, pciGrant;
    int errCount, compares, cycles;

    pci_concurrency_arbitration_control u_pci_concurrency_arbitration_control (.clk, .rst_n, .regReq,
        .regRdata, .cpuBurstReady_n, .cpuAddressStrobe_n, .pciReq, .peerTraffic(st[0]), .peerLocked(st[1]),
        .cpuMemCycle(st[2]), .cpuPciWrite(st[3]), .cpuQwordWrite(st[4]), .cpuPciBufEmpty, .dramBufEmpty,
        .hostBusAck, .pciDramXfer(st[5]), .pciDramStart(st[6]), .pciDwordIndex(idx), .pciBusIdle(st[7]),
        .pciGrant, .cpuOwnsPci, .cpuBackoff, .hostBusRequest, .cpuPciBurstEn, .cpuPciPostEn, .snoopStrobe,
        .pciDisconnect, .cpuIdleFlag);
    host_side_model u_host_side_model (.clk, .rst_n, .hostBusRequest, .hostBusAck, .cpuPciBufEmpty,
        .dramBufEmpty);

    always #12.5 clk = ~clk;

    task chk(input logic [7:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            errCount++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wr(input logic [7:0] a, d);
        @(posedge clk);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        regReq <= '0;
    endtask

    task rd(input logic [7:0] a, e);
        @(posedge clk);
        regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        regReq <= '0;
        #1 chk(regRdata, e);
    endtask

    // time from burst ready to idle flag, then strobe clears it
    task idle(input logic [2:0] s);
        int n;
        wr(8'h50, {s, 5'h00});
        cpuBurstReady_n <= 1'b0;
        cpuAddressStrobe_n <= 1'b1;
        @(posedge clk);
        cpuBurstReady_n <= 1'b1;
        n = 0;
        #1;
        while (cpuIdleFlag !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        // timeout is field plus one, flag one clock later
        chk(8'(n), {5'h00, s} + 8'h02);
        @(posedge clk);
        cpuAddressStrobe_n <= 1'b0;
        cyc(3);
        #1 chk({7'h0, cpuIdleFlag}, 8'h00);
    endtask

    // policy outputs against status inputs
    task pol(input logic [7:0] p, s, input logic [1:0] i);
        logic [4:0] e;
        e[4] = s[0] && !(p[3] && !p[0] && s[2] && !s[1]);
        e[3] = !p[2] || (s[3] && s[4]);
        e[2] = 1'b1;
        e[1] = s[5] && (s[6] || !p[1]);
        e[0] = p[1] && s[5] && i == 2'h3;
        wr(8'h50, p);
        st <= s;
        idx <= i;
        cyc(2);
        #1 chk({3'h0, cpuBackoff, cpuPciBurstEn, cpuPciPostEn, snoopStrobe, pciDisconnect}, {3'h0, e});
    endtask

    // busy cpu keeps bus, idle cpu yields, then bus returns
    task arb(input logic o, input logic [3:0] r, e);
        int n;
        logic h;
        wr(8'h50, {7'h00, o});
        pciReq <= r;
        st <= 8'h80;
        cyc(6);
        #1 chk({4'h0, pciGrant}, 8'h00);
        @(posedge clk);
        cpuBurstReady_n <= 1'b0;
        cpuAddressStrobe_n <= 1'b1;
        @(posedge clk);
        cpuBurstReady_n <= 1'b1;
        h = 1'b0;
        n = 0;
        #1;
        while (pciGrant === 4'h0 && n < 40)
        begin
            @(posedge clk);
            #1;
            h = h | hostBusRequest;
            n++;
        end
        chk({3'h0, h, pciGrant}, {3'h0, o | r[3], e});
        chk({7'h0, cpuOwnsPci}, 8'h00);
        @(posedge clk);
        pciReq <= 4'h0;
        cpuAddressStrobe_n <= 1'b0;
        cyc(8);
        #1 chk({7'h0, cpuOwnsPci}, 8'h01);
    endtask

    task completeRun;
        $display("compares %0d errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errCount++;
            completeRun();
        end
    end

    initial
    begin
        {clk, rst_n, cpuBurstReady_n, cpuAddressStrobe_n} = 4'h2;
        {regReq, pciReq, st, idx} = '0;
        {errCount, compares, cycles} = '0;
        cyc(6);
        rst_n <= 1'b1;
        rd(8'h50, 8'h40);
        wr(8'h50, 8'hFF);
        rd(8'h50, 8'hEF);
        wr(8'h51, 8'h00);
        rd(8'h51, 8'h00);
        rd(8'h50, 8'hEF);
        idle(3'h0);
        idle(3'h7);
        pol(8'h40, 8'h01, 2'h0);
        pol(8'h48, 8'h05, 2'h0);
        pol(8'h48, 8'h07, 2'h0);
        pol(8'h49, 8'h05, 2'h0);
        pol(8'h44, 8'h08, 2'h0);
        pol(8'h44, 8'h18, 2'h0);
        pol(8'h42, 8'h20, 2'h3);
        pol(8'h42, 8'h60, 2'h2);
        pol(8'h40, 8'h20, 2'h3);
        arb(1'b0, 4'h1, 4'h1);
        arb(1'b1, 4'h1, 4'h1);
        arb(1'b0, 4'h9, 4'h8);
        completeRun();
    end
endmodule
